// ===== design/rts_pkg.sv
// root thread scoreboard types, constants and shared decoding.
// assumes one pipeline clock and synchronous active-high reset.
package rts_pkg;

    // =====================================================================
    // sizes and reset values
    // =====================================================================
    localparam int          RTS_DEPS     = 8;
    localparam int          RTS_SB_SIZE  = 262144;
    localparam logic [18:0] RTS_CNT_ZERO = 19'h0_0000;
    localparam logic [18:0] RTS_CNT_ONE  = 19'h0_0001;
    localparam logic [8:0]  RTS_POS_ZERO = 9'h000;

    // =====================================================================
    // carriers
    // =====================================================================
    typedef struct packed {
        logic [8:0] y;
        logic [8:0] x;
    } rts_coord_t;

    typedef struct packed {
        rts_coord_t coord;
        logic       root;
        logic       synced;
    } rts_thread_t;

    typedef struct packed {
        logic signed [8:0] offset_y;
        logic signed [8:0] offset_x;
    } rts_offset_t;

    typedef struct packed {
        logic                  sb_enable;
        logic [7:0]            dep_enable;
        rts_offset_t [7:0]     dep;
    } rts_sb_cfg_t;

    typedef struct packed {
        rts_coord_t resolution;
        rts_coord_t start;
        rts_offset_t outer_step;
        rts_offset_t inner_step;
    } rts_loop_t;

    typedef struct packed {
        rts_loop_t global_loop;
        rts_loop_t local_loop;
    } rts_walk_cfg_t;

    typedef enum logic [1:0] {
        RTS_ST_IDLE = 2'h0,
        RTS_ST_HOLD = 2'h1,
        RTS_ST_SEND = 2'h2
    } rts_state_e_t;

    typedef struct packed {
        rts_state_e_t       st;
        rts_thread_t        pend;
        logic               req_ready;
        logic               disp_valid;
        logic               stalled;
        logic               release_credit;
        logic [18:0]        inflight;
        rts_coord_t         walk_first;
        rts_coord_t         walk_inner;
        rts_coord_t         walk_outer;
    } rts_top_state_t;

    typedef struct packed {
        logic [RTS_SB_SIZE-1:0] bits;
    } rts_sb_state_t;

    // =====================================================================
    // decoding used by the scoreboard module
    // =====================================================================
    function automatic logic [17:0] rts_coord_idx(input rts_coord_t c);
        rts_coord_idx = {c.y, c.x};
    endfunction

    function automatic rts_coord_t rts_coord_add(input rts_coord_t c, input rts_offset_t o);
        rts_coord_t r;
        r.x = 9'(c.x + $unsigned(o.offset_x));
        r.y = 9'(c.y + $unsigned(o.offset_y));
        rts_coord_add = r;
    endfunction

endpackage

// ===== design/rts_sb_array.sv
// scoreboard storage: one in-flight bit per coordinate, eight read ports.
// assumes mark and clear-all never share a cycle.
`timescale 1ns/100ps

module rts_sb_array (
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic        i_mark,
    input  wire logic [17:0] i_mark_idx,
    input  wire logic        i_clear,
    input  wire logic [17:0] i_clear_idx,
    input  wire logic        i_clear_all,
    input  wire logic [17:0] i_rd_idx [8],
    output logic      [7:0]  o_rd_bit
);

    // =====================================================================
    // state
    // =====================================================================
    rts_pkg::rts_sb_state_t s;
    rts_pkg::rts_sb_state_t next_s;

    always_comb begin
        next_s = s;
        if (i_clear_all) begin
            next_s.bits = '0;                               // see [RQ19]
        end else begin
            if (i_clear) begin
                next_s.bits[i_clear_idx] = 1'b0;            // see [RQ3]
            end
            // mark wins over a same-cycle clear
            if (i_mark) begin
                next_s.bits[i_mark_idx] = 1'b1;             // see [RQ2]
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            s <= '0;                                        // see [RQ19]
        end else begin
            s <= next_s;
        end
    end

    // =====================================================================
    // read ports
    // =====================================================================
    genvar k;
    generate
        for (k = 0; k < rts_pkg::RTS_DEPS; k++) begin : g_rd
            assign o_rd_bit[k] = s.bits[i_rd_idx[k]];       // see [RQ20]
        end
    endgenerate

endmodule

// ===== design/rts_scoreboard.sv
// root thread scoreboard: holds a root thread until its neighbours are clear,
// then hands it to the thread dispatch unit.
// assumes all inputs are on the pipeline clock.
`timescale 1ns/100ps

// Behaviour
// [RQ1] entries indexed by 18-bit coordinate, 9-bit x and 9-bit y
// [RQ2] dispatching a root thread marks its coordinate entry in flight
// [RQ3] root thread termination clears its coordinate entry
// [RQ4] up to eight dependencies, each a signed x and y offset
// [RQ5] checking only with global enable; each dependency needs its own enable
// [RQ6] hold thread while any enabled coordinate plus offset is marked
// [RQ7] own marked entry stalls only if zero offset dependency is enabled
// [RQ8] issuer keeps work within 512 by 512 coordinates to avoid aliasing
// [RQ9] child threads bypass marking, clearing and stalling entirely; the code holds a synced child for release when scoreboard is off
// [RQ10] issuer sends no synchronized root threads while scoreboard is used
// [RQ11] without scoreboard, synchronized root threads wait for parent release
// [RQ12] progressive or field picture: issuer enables at most four neighbours
// [RQ13] pair coded frame: issuer enables three, five or eight dependencies
// [RQ14] issuer supplies correct availability flags; device trusts them
// [RQ15] left pair neighbours may be one group: left or extra left
// [RQ16] second frame pair macroblock always depends on the first one
// [RQ17] second decoding style: at most one dependency, on upper neighbour
// [RQ18] walker takes resolution, start, outer and inner step per loop
// [RQ19] reset, or flush with nothing in flight, clears every entry; the code drops a flush racing a root dispatch
// [RQ20] dependencies rechecked within one cycle of any mark or clear
module rts_scoreboard (
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire logic                   i_flush,
    input  wire rts_pkg::rts_sb_cfg_t   i_sb_cfg,
    input  wire rts_pkg::rts_walk_cfg_t i_walk_cfg,
    input  wire logic                   i_req_valid,
    input  wire rts_pkg::rts_thread_t   i_req,
    input  wire logic                   i_disp_ready,
    input  wire logic                   i_term_valid,
    input  wire rts_pkg::rts_thread_t   i_term,
    input  wire logic                   i_srt_release,
    output logic                        o_req_ready,
    output logic                        o_disp_valid,
    output rts_pkg::rts_thread_t        o_disp,
    output logic                        o_stalled,
    output logic                 [18:0] o_inflight,
    output rts_pkg::rts_coord_t         o_walk_first,
    output rts_pkg::rts_coord_t         o_walk_inner,
    output rts_pkg::rts_coord_t         o_walk_outer
);

    // =====================================================================
    // state and wires
    // =====================================================================
    rts_pkg::rts_top_state_t s;
    rts_pkg::rts_top_state_t next_s;

    logic        [17:0]     rd_idx [8];
    logic        [7:0]      rd_bit;
    logic        [7:0]      dep_hit;

    logic                   stall_sb;
    logic                   stall_srt;

    logic                   handshake;

    logic                   mark_en;
    logic        [17:0]     mark_idx;

    logic                   clear_en;
    logic        [17:0]     clear_idx;
    logic                   clear_all;

    rts_pkg::rts_coord_t    walk_sum;

    // =====================================================================
    // dependency addresses
    // =====================================================================
    // reads follow the held thread, so a mark or clear is seen the next cycle
    genvar k;

    generate
        for (k = 0; k < rts_pkg::RTS_DEPS; k++) begin : g_dep
            assign rd_idx[k] = rts_pkg::rts_coord_idx(
                rts_pkg::rts_coord_add(s.pend.coord, i_sb_cfg.dep[k]));  // see [RQ4]
        end
    endgenerate

    rts_sb_array u_sb (
        .i_mclk      (i_mclk),
        .i_reset     (i_reset),
        .i_mark      (mark_en),
        .i_mark_idx  (mark_idx),
        .i_clear     (clear_en),
        .i_clear_idx (clear_idx),
        .i_clear_all (clear_all),
        .i_rd_idx    (rd_idx),
        .o_rd_bit    (rd_bit)
    );

    // =====================================================================
    // stall decision
    // =====================================================================
    // own entry is read only via a zero offset dependency
    assign dep_hit   = rd_bit & i_sb_cfg.dep_enable;                     // see [RQ5] see [RQ7]

    assign stall_sb  = i_sb_cfg.sb_enable & s.pend.root & (|dep_hit);    // see [RQ6] see [RQ9]
    assign stall_srt = ~i_sb_cfg.sb_enable & s.pend.synced
                       & ~s.release_credit;                              // see [RQ11]

    // =====================================================================
    // mark, clear and flush
    // =====================================================================
    assign handshake = s.disp_valid & i_disp_ready;

    assign mark_en   = handshake & s.pend.root & i_sb_cfg.sb_enable;     // see [RQ2] see [RQ9]
    assign mark_idx  = rts_pkg::rts_coord_idx(s.pend.coord);             // see [RQ1]

    assign clear_en  = i_term_valid & i_term.root;                       // see [RQ3] see [RQ9]
    assign clear_idx = rts_pkg::rts_coord_idx(i_term.coord);
    // a flush racing a root dispatch is dropped
    assign clear_all = i_flush & (s.inflight == rts_pkg::RTS_CNT_ZERO)
                       & ~(handshake & s.pend.root);                     // see [RQ19]

    // =====================================================================
    // walker start point
    // =====================================================================
    // only the first position and one inner and one outer step of the local loop are formed here
    always_comb begin
        walk_sum.x = 9'(i_walk_cfg.global_loop.start.x + i_walk_cfg.local_loop.start.x);
        walk_sum.y = 9'(i_walk_cfg.global_loop.start.y + i_walk_cfg.local_loop.start.y);

        if (walk_sum.x >= i_walk_cfg.global_loop.resolution.x) begin
            walk_sum.x = rts_pkg::RTS_POS_ZERO;
        end
        if (walk_sum.y >= i_walk_cfg.global_loop.resolution.y) begin
            walk_sum.y = rts_pkg::RTS_POS_ZERO;
        end
    end

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        next_s = s;

        next_s.walk_first = walk_sum;                                    // see [RQ18]
        next_s.walk_inner = rts_pkg::rts_coord_add(walk_sum, i_walk_cfg.local_loop.inner_step);
        next_s.walk_outer = rts_pkg::rts_coord_add(walk_sum, i_walk_cfg.local_loop.outer_step);

        unique case (s.st)
            rts_pkg::RTS_ST_IDLE: begin
                next_s.stalled = 1'b0;

                if (i_req_valid) begin
                    next_s.pend      = i_req;
                    next_s.req_ready = 1'b0;
                    next_s.st        = rts_pkg::RTS_ST_HOLD;
                end
            end

            rts_pkg::RTS_ST_HOLD: begin
                if (stall_sb | stall_srt) begin
                    next_s.stalled = 1'b1;                               // see [RQ6]
                end else begin
                    next_s.stalled    = 1'b0;
                    next_s.disp_valid = 1'b1;                            // see [RQ20]
                    next_s.st         = rts_pkg::RTS_ST_SEND;

                    if (~i_sb_cfg.sb_enable & s.pend.synced) begin
                        next_s.release_credit = 1'b0;                    // see [RQ11]
                    end
                end
            end

            rts_pkg::RTS_ST_SEND: begin
                if (i_disp_ready) begin
                    next_s.disp_valid = 1'b0;
                    next_s.req_ready  = 1'b1;
                    next_s.st         = rts_pkg::RTS_ST_IDLE;
                end
            end

            default: begin
                next_s.st         = rts_pkg::RTS_ST_IDLE;
                next_s.disp_valid = 1'b0;
                next_s.req_ready  = 1'b1;
            end
        endcase

        // a release arriving as a credit is spent still counts
        if (i_srt_release) begin
            next_s.release_credit = 1'b1;
        end

        // in-flight root count
        if (handshake & s.pend.root & ~clear_en) begin
            next_s.inflight = 19'(s.inflight + rts_pkg::RTS_CNT_ONE);
        end else if (clear_en & ~(handshake & s.pend.root)
                     & (s.inflight != rts_pkg::RTS_CNT_ZERO)) begin
            next_s.inflight = 19'(s.inflight - rts_pkg::RTS_CNT_ONE);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            s            <= '0;
            s.st         <= rts_pkg::RTS_ST_IDLE;
            s.req_ready  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign o_req_ready  = s.req_ready;
    assign o_disp_valid = s.disp_valid;
    assign o_disp       = s.pend;

    assign o_stalled    = s.stalled;
    assign o_inflight   = s.inflight;

    assign o_walk_first = s.walk_first;
    assign o_walk_inner = s.walk_inner;
    assign o_walk_outer = s.walk_outer;

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge i_mclk); endclocking

    default disable iff (i_reset);

    sequence s_disp_taken;
        o_disp_valid && i_disp_ready;
    endsequence

    sequence s_root_held_sb;
        s.st == rts_pkg::RTS_ST_HOLD && i_sb_cfg.sb_enable && s.pend.root;
    endsequence

    AST_IDX_MAP: assert property (                                       // see [RQ1]
        mark_en |-> mark_idx[8:0] == o_disp.coord.x && mark_idx[17:9] == o_disp.coord.y)
        else $error("index not y,x");

    AST_MARK_SET: assert property (                                      // see [RQ2]
        s_disp_taken ##0 (o_disp.root && i_sb_cfg.sb_enable)
        |=> u_sb.s.bits[$past(mark_idx)])
        else $error("entry not marked");

    AST_CLEAR_DONE: assert property (                                    // see [RQ3]
        (clear_en && !(mark_en && mark_idx == clear_idx))
        |=> !u_sb.s.bits[$past(clear_idx)])
        else $error("entry not cleared");

    AST_DISABLED_PASS: assert property (                                 // see [RQ5]
        s.st == rts_pkg::RTS_ST_HOLD && !i_sb_cfg.sb_enable && !s.pend.synced
        |=> o_disp_valid && !o_stalled)
        else $error("stalled while disabled");

    AST_DEP_STALL: assert property (                                     // see [RQ6]
        s_root_held_sb ##0 (|dep_hit)
        |=> !o_disp_valid && o_stalled)
        else $error("released on marked dep");

    AST_RELEASE_FAST: assert property (                                  // see [RQ20]
        s_root_held_sb ##0 dep_hit == 8'h00
        |=> o_disp_valid ##0 s.st == rts_pkg::RTS_ST_SEND)
        else $error("release late");

    AST_CHILD_BYPASS: assert property (                                  // see [RQ9]
        s.st == rts_pkg::RTS_ST_HOLD && !s.pend.root && !s.pend.synced
        |=> o_disp_valid ##1 (!o_disp_valid || !mark_en))
        else $error("child marked");

    AST_SRT_WAIT: assert property (                                      // see [RQ11]
        s.st == rts_pkg::RTS_ST_HOLD && !i_sb_cfg.sb_enable && s.pend.synced
        && !s.release_credit
        |=> !o_disp_valid)
        else $error("released without message");

    AST_FLUSH_CLEAR: assert property (                                   // see [RQ19]
        clear_all |=> u_sb.s.bits == '0 && o_inflight == rts_pkg::RTS_CNT_ZERO)
        else $error("flush left marks");

    AST_WALK_FIRST: assert property (                                    // see [RQ18]
        $stable(i_walk_cfg) && walk_sum.x == 9'(i_walk_cfg.global_loop.start.x
        + i_walk_cfg.local_loop.start.x) |=> o_walk_first.x == $past(walk_sum.x))
        else $error("walker start wrong");

    AST_READY_BACK: assert property (
        s_disp_taken |=> o_req_ready && !o_disp_valid ##1 1'b1)
        else $error("ready not back");

    AST_CREDIT_SET: assert property ( // see [RQ11]
        i_srt_release |=> s.release_credit)
        else $error("release lost");

    AST_COUNT_DOWN: assert property ( // see [RQ3]
        clear_en && !handshake && o_inflight != rts_pkg::RTS_CNT_ZERO
        |=> o_inflight == $past(o_inflight) - rts_pkg::RTS_CNT_ONE)
        else $error("count not lowered");

endmodule

// ===== test/rts_disp_partner.sv
// thread dispatch unit model for the dispatch handshake.
// assumes the shared clock and synchronous reset.
`timescale 1ns/100ps

module rts_disp_partner (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    input  wire logic i_disp_valid,
    input  wire logic i_slow,
    output logic      o_disp_ready
);
    // =====================================================================
    // ready: high when prompt, after three valid cycles when slow
    // =====================================================================
    logic [1:0] wait_cnt;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wait_cnt     <= 2'h0;
            o_disp_ready <= 1'b0;
        end else if (o_disp_ready && i_disp_valid) begin
            wait_cnt     <= 2'h0;
            o_disp_ready <= !i_slow;
        end else if (!i_slow) begin
            o_disp_ready <= 1'b1;
        end else if (i_disp_valid) begin
            if (wait_cnt == 2'h2) begin
                o_disp_ready <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule

// ===== test/rts_scoreboard_tb.sv
// bench: directed stall cases, then random traffic against a model.
// assumes a design that holds one thread at a time.
`timescale 1ns/100ps

module rts_scoreboard_tb;
    // =====================================================================
    // signals and model state
    // =====================================================================
    logic mclk, reset, flush, req_valid, disp_ready, term_valid, srt_release, slow;
    logic req_ready, disp_valid, stalled, hs;
    logic [18:0]           inflight;
    rts_pkg::rts_sb_cfg_t   sb_cfg;
    rts_pkg::rts_walk_cfg_t walk_cfg;
    rts_pkg::rts_thread_t   req, term, disp, exp_thr;
    rts_pkg::rts_coord_t    walk_first, walk_inner, walk_outer;
    rts_pkg::rts_coord_t    q[$];
    bit                     sb[int];
    bit                     credit;
    int error_cnt, samples_checked, cyc, cnt, n, k, i;
    int seed = 54808;

    rts_scoreboard rts_scoreboard_inst (.i_mclk(mclk), .i_reset(reset), .i_flush(flush),
        .i_sb_cfg(sb_cfg), .i_walk_cfg(walk_cfg), .i_req_valid(req_valid), .i_req(req),
        .i_disp_ready(disp_ready), .i_term_valid(term_valid), .i_term(term),
        .i_srt_release(srt_release), .o_req_ready(req_ready), .o_disp_valid(disp_valid),
        .o_disp(disp), .o_stalled(stalled), .o_inflight(inflight),
        .o_walk_first(walk_first), .o_walk_inner(walk_inner), .o_walk_outer(walk_outer));
    rts_disp_partner rts_disp_partner_inst (.i_mclk(mclk), .i_reset(reset),
        .i_disp_valid(disp_valid), .i_slow(slow), .o_disp_ready(disp_ready));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // =====================================================================
    // compares and verdict
    // =====================================================================
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_thr(input rts_pkg::rts_thread_t got, input rts_pkg::rts_thread_t exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t thread %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [18:0] got, input logic [18:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    // =====================================================================
    // model: index y*512+x, wrap mod 512
    // =====================================================================
    function automatic int idx(input rts_pkg::rts_coord_t c);
        idx = int'(c.y) * 512 + int'(c.x);
    endfunction

    function automatic bit blocked(input rts_pkg::rts_thread_t t);
        int x, y;
        blocked = 1'b0;
        if (sb_cfg.sb_enable && t.root) begin
            for (int d = 0; d < 8; d++) begin
                x = (int'(t.coord.x) + int'(sb_cfg.dep[d].offset_x)) & 511;
                y = (int'(t.coord.y) + int'(sb_cfg.dep[d].offset_y)) & 511;
                if (sb_cfg.dep_enable[d] && sb.exists(y * 512 + x)) blocked = 1'b1;
            end
        end else if (!sb_cfg.sb_enable && t.synced && !credit) begin
            blocked = 1'b1;
        end
    endfunction

    function automatic rts_pkg::rts_thread_t th(input int x, input int y, input bit r, input bit s);
        th.coord.x = 9'(x);
        th.coord.y = 9'(y);
        th.root    = r;
        th.synced  = s;
    endfunction

    // sample, compare, then advance the model
    task automatic tick();
        @(posedge mclk);
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            give_verdict();
        end
        hs = (disp_valid === 1'b1) && (disp_ready === 1'b1);
        if (hs) begin
            check_thr(disp, exp_thr);
            check_bit(blocked(exp_thr), 1'b0);
        end
        if (reset) begin
            sb.delete();
            q.delete();
            cnt    = 0;
            credit = 1'b0;
        end else begin
            if (term_valid && term.root) begin
                sb.delete(idx(term.coord));
                if (cnt > 0) cnt--;
            end
            if (hs && exp_thr.root) begin
                cnt++;
                q.push_back(exp_thr.coord);
                if (sb_cfg.sb_enable) sb[idx(exp_thr.coord)] = 1'b1;
            end
            if (srt_release) credit = 1'b1;
            else if (hs && exp_thr.synced && !sb_cfg.sb_enable) credit = 1'b0;
        end
    endtask

    // =====================================================================
    // drivers
    // =====================================================================
    task automatic submit(input rts_pkg::rts_thread_t t);
        exp_thr = t;
        req       <= t;
        req_valid <= 1'b1;
        for (int w = 0; w < 50; w++) begin
            tick();
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
    endtask

    // random ends unblock waiting threads
    task automatic wait_disp(input bit rel, input bit rnd, output int cycles);
        bit dt;
        for (cycles = 0; cycles < 300; cycles++) begin
            tick();
            if (hs) break;
            dt = rnd && q.size() > 0 && (($random(seed) & 3) == 0);
            if (dt) term.coord <= q.pop_front();
            term.root   <= 1'b1;
            term_valid  <= dt;
            srt_release <= rel && (cycles == 3);
        end
        if (!hs) begin
            error_cnt++;
            $display("MISMATCH t=%0t no dispatch", $time);
            give_verdict();
        end
        term_valid  <= 1'b0;
        srt_release <= 1'b0;
    endtask

    task automatic term_one(input rts_pkg::rts_coord_t c, input bit r);
        term.coord <= c;
        term.root  <= r;
        term_valid <= 1'b1;
        tick();
        term_valid <= 1'b0;
        tick();
    endtask

    task automatic stall_check(input rts_pkg::rts_thread_t t);
        submit(t);
        repeat (8) tick();
        check_bit(stalled, 1'b1);
        check_bit(disp_valid, 1'b0);
    endtask

    task automatic quick(input rts_pkg::rts_thread_t t);
        submit(t);
        wait_disp(1'b0, 1'b0, n);
        check_bit(n <= 4, 1'b1);
    endtask

    task automatic drain_count();
        while (q.size() > 0) term_one(q.pop_front(), 1'b1);
        repeat (2) tick();
        check_val(inflight, 19'(cnt));
    endtask

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        {flush, req_valid, term_valid, srt_release, slow} = 5'h00;
        sb_cfg = '0;
        walk_cfg = '0;
        req = '0;
        term = '0;
        reset = 1'b1;
        repeat (12) tick();
        reset <= 1'b0;
        tick();
        check_bit(req_ready, 1'b1);
        check_val(inflight, 19'h0_0000);
        walk_cfg.global_loop.resolution <= '{y: 9'h044, x: 9'h078};
        walk_cfg.global_loop.start      <= '{y: 9'h003, x: 9'h002};
        walk_cfg.local_loop.start       <= '{y: 9'h001, x: 9'h001};
        walk_cfg.local_loop.outer_step  <= '{offset_y: 9'h000, offset_x: 9'h001};
        walk_cfg.local_loop.inner_step  <= '{offset_y: 9'h002, offset_x: 9'h1fe};
        repeat (3) tick();
        check_val({1'b0, walk_first}, {1'b0, 9'h004, 9'h003});
        check_val({1'b0, walk_inner}, {1'b0, 9'h006, 9'h001});
        check_val({1'b0, walk_outer}, {1'b0, 9'h004, 9'h004});
        sb_cfg.sb_enable     <= 1'b1;
        sb_cfg.dep_enable    <= 8'h01;
        sb_cfg.dep[0].offset_x <= 9'h1ff;
        quick(th(5, 5, 1, 0));
        stall_check(th(6, 5, 1, 0));
        term_one(th(5, 5, 1, 0).coord, 1'b1);
        wait_disp(1'b0, 1'b0, n);
        check_bit(n <= 4, 1'b1);
        quick(th(6, 5, 1, 0));
        sb_cfg.dep_enable <= 8'h03;
        stall_check(th(6, 5, 1, 0));
        term_one(th(6, 5, 1, 0).coord, 1'b1);
        wait_disp(1'b0, 1'b0, n);
        sb_cfg.dep_enable <= 8'h01;
        quick(th(7, 5, 0, 0));
        term_one(th(6, 5, 0, 0).coord, 1'b0);
        stall_check(th(7, 5, 1, 0));
        term_one(th(6, 5, 0, 0).coord, 1'b1);
        wait_disp(1'b0, 1'b0, n);
        sb_cfg.sb_enable <= 1'b0;
        quick(th(8, 5, 1, 0));
        stall_check(th(9, 5, 1, 1));
        wait_disp(1'b1, 1'b0, n);
        drain_count();
        sb_cfg.sb_enable <= 1'b1;
        quick(th(5, 5, 1, 0));
        reset <= 1'b1;
        repeat (2) tick();
        reset <= 1'b0;
        tick();
        quick(th(6, 5, 1, 0));
        // small coordinates force collisions
        for (k = 0; k < 30; k++) begin
            sb_cfg.sb_enable  <= ($random(seed) & 3) != 0;
            sb_cfg.dep_enable <= 8'($random(seed));
            for (i = 0; i < 8; i++) begin
                sb_cfg.dep[i] <= '{offset_y: 9'(($random(seed) & 3) - 1),
                                   offset_x: 9'(($random(seed) & 3) - 1)};
            end
            slow <= 1'($random(seed));
            tick();
            submit(th($random(seed) & 7, $random(seed) & 7, ($random(seed) & 3) != 0, 0));
            wait_disp(1'b0, 1'b1, n);
        end
        drain_count();
        flush <= 1'b1;
        tick();
        flush <= 1'b0;
        quick(th(1, 1, 1, 0));
        give_verdict();
    end
endmodule
